// File: rtl/micl_pkg.sv
`default_nettype none
package micl_pkg;
    localparam int STATUS_W = 16;
    localparam int DATA_W = 32;
    localparam int ADDR_W = 12;
    // Status word bit positions.
    localparam int B_SUPPLY = 0;
    localparam int B_LOWBAT = 1;
    localparam int B_EXTALM = 2;
    localparam int B_T1_HI = 3;
    localparam int B_T2_HI = 4;
    localparam int B_T1_LO = 5;
    localparam int B_T2_LO = 6;
    localparam int B_DT = 7;
    localparam int B_AIR = 8;
    localparam int B_REV = 9;
    localparam int B_OVER = 11;
    localparam int B_LEAKA = 12;
    localparam int B_LEAKB = 13;
    localparam int B_ALMA = 14;
    localparam int B_ALMB = 15;
    // Register byte offsets.
    localparam logic [11:0] A_STATUS = 12'h000;
    localparam logic [11:0] A_CTRL = 12'h004;
    localparam logic [11:0] A_MASK = 12'h008;
    localparam logic [11:0] A_STATE = 12'h00c;
    localparam logic [11:0] A_EVCNT = 12'h010;
    localparam logic [11:0] A_T1 = 12'h014;
    localparam logic [11:0] A_T2 = 12'h018;
    localparam logic [11:0] A_FLOW = 12'h01c;
    localparam logic [11:0] A_POWER = 12'h020;
    localparam logic [11:0] A_INFO_IDX = 12'h024;
    localparam logic [11:0] A_INFO_RD = 12'h028;
    localparam logic [11:0] A_CFG_IDX = 12'h02c;
    localparam logic [11:0] A_CFG_RD = 12'h030;
    localparam logic [11:0] A_CFG_CNT = 12'h034;
    // CTRL bit positions.
    localparam int C_FINISH = 0;
    localparam int C_RADIO = 1;
    localparam int C_SETUP = 2;
    localparam int C_LEAVE = 3;
    // Substitution values, in 0.01 degC, 1 l/h and 0.1 kW.
    localparam logic [15:0] T_MIN = 16'h0000;
    localparam logic [15:0] T_MAX = 16'h4844;
    localparam logic [15:0] FLOW_ERR = 16'h0000;
    localparam logic [15:0] POWER_ERR = 16'h0000;
    localparam logic [15:0] MASK_RST = 16'hfbff;
    localparam int INFO_DEPTH = 50;
    localparam int CFG_MAX = 25;
    typedef enum logic [1:0] {MICL_TRANSPORT, MICL_NORMAL, MICL_TEST} micl_mode_t;
    typedef struct packed {
        logic [15:0] t1;
        logic [15:0] t2;
        logic [15:0] flow;
        logic [15:0] power;
    } micl_meas_t;
    typedef struct packed {
        logic [31:0] stamp;
        logic [15:0] status;
        logic [31:0] heat;
        logic [31:0] cool;
    } micl_info_t;
    typedef struct packed {
        logic [31:0] stamp;
        logic [15:0] cfg_no;
        logic [31:0] heat;
        logic [31:0] cool;
        logic [31:0] vol;
        logic [31:0] hours;
        logic [15:0] t_offset;
    } micl_cfg_t;
endpackage
`default_nettype wire

// File: rtl/micl_logger.sv
`default_nettype none
// Overview of operation
// - Sensor faults stop energy accumulation depending on that sensor; display dashes.
// - Faulty temperature reads 0.00 degC when shorted, 185.00 degC when open.
// - Invalid temperature difference alone is not a temperature sensor fault.
// - Any temperature fault reports power 0.0 kW and dashes difference and power.
// - Flow fault reports flow 0 l/h and power 0.0 kW, dashes flow and power.
// - Flow above maximum approved flow is not a flow sensor fault.
// - Status bits 3-6 for sensor range faults, bit 7 invalid difference.
// - Status bit 8 air, bit 9 reversed flow, bit 11 overflow; bit 10 unused.
// - Status bits 12-15 leakage and external alarm on pulse inputs A and B.
// - Transport state drives display but writes no info log entries and counts no events; configuration logs are still written.
// - Transport state lasts until first flow; logging then starts automatically.
// - Transport uses power-saving sequence, afterwards the configured rate sequence.
// - Finish-setup command leaves transport state and blocks configuration menu.
// - Transport state is never re-entered except by total reset.
// - Radio off at delivery, switched on by first integration.
// - Menu or forced dial-up enables radio without leaving transport state.
// - Verification menu disables radio; integration or dial-up cannot re-enable it.
// - Each status change logs stamp, status, heat and cooling energy; keep 50.
// - Only country-enabled status bits generate events.
// - Event counts and logs, except in transport state or with top separated; a queued supply-restore entry is still counted and logged with top separated.
// - Configuration changes log stamp, number, energies, volume, hours, offset; max 25.
// - Configuration log entry written whenever the menu was accessed, until 25 entries are held.
// - Alert indicator flashes whenever status word is nonzero.
// - Supply-loss bit is never in current status but is logged.
module micl_logger #(
    parameter int FLASH_DIV = 8
) (
    // Clock and reset.
    input wire logic pclk,
    input wire logic presetn,
    input wire logic clk_en,
    // APB slave.
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [micl_pkg::ADDR_W-1:0] paddr,
    input wire logic [micl_pkg::DATA_W-1:0] pwdata,
    output logic [micl_pkg::DATA_W-1:0] prdata,
    output logic pready,
    output logic pslverr,
    // Fault inputs from front ends.
    input wire logic t1_open,
    input wire logic t1_short,
    input wire logic t2_open,
    input wire logic t2_short,
    input wire logic dt_invalid,
    input wire logic air_in_flow,
    input wire logic flow_reversed,
    input wire logic flow_over_1h,
    input wire logic low_battery,
    input wire logic ext_alarm,
    input wire logic leak_a,
    input wire logic leak_b,
    input wire logic alarm_a,
    input wire logic alarm_b,
    input wire logic supply_restored,
    // Raw measurements and counters.
    input wire micl_pkg::micl_meas_t meas_raw,
    input wire logic [31:0] time_stamp,
    input wire logic [31:0] heat_energy_register,
    input wire logic [31:0] cooling_energy_register,
    input wire logic [31:0] volume_count,
    input wire logic [31:0] hour_count,
    input wire logic [15:0] temp_offset,
    input wire logic [15:0] cfg_number,
    // Operator events.
    input wire logic integration,
    input wire logic forced_dialup,
    input wire logic setup_exit,
    input wire logic test_menu_enter,
    input wire logic top_separated,
    input wire logic [1:0] rate_code,
    // Outputs to the meter.
    output logic heat_acc_en,
    output logic cool_acc_en,
    output logic dash_temp,
    output logic dash_flow,
    output logic dash_power,
    output logic info_flash,
    output logic radio_on,
    output logic setup_open,
    output logic [1:0] meas_seq,
    output logic [micl_pkg::STATUS_W-1:0] status_word
);
    localparam int IDX_W = $clog2(micl_pkg::INFO_DEPTH);
    localparam int CIDX_W = $clog2(micl_pkg::CFG_MAX);

    micl_pkg::micl_mode_t mode_reg;
    logic [15:0] mask_reg;
    logic [15:0] prev_reg;
    logic [15:0] evcnt_reg;
    logic [15:0] status_next;
    logic [IDX_W-1:0] wptr_reg;
    logic [IDX_W-1:0] info_idx_reg;
    logic [CIDX_W:0] cfg_cnt_reg;
    logic [CIDX_W-1:0] cfg_idx_reg;
    logic setup_open_reg;
    logic radio_reg;
    logic supply_pend_reg;
    logic [7:0] flash_cnt_reg;
    logic flash_reg;
    micl_pkg::micl_meas_t meas_reg;
    micl_pkg::micl_info_t info_mem [micl_pkg::INFO_DEPTH];
    micl_pkg::micl_cfg_t cfg_mem [micl_pkg::CFG_MAX];

    logic temp_fault;
    logic flow_fault;
    logic wr_en;
    logic rd_en;
    logic event_now;
    logic cfg_log;
    logic unmapped;

    function automatic logic known_addr(input logic [11:0] a);
        case (a)
            micl_pkg::A_STATUS, micl_pkg::A_CTRL, micl_pkg::A_MASK, micl_pkg::A_STATE,
            micl_pkg::A_EVCNT, micl_pkg::A_T1, micl_pkg::A_T2, micl_pkg::A_FLOW,
            micl_pkg::A_POWER, micl_pkg::A_INFO_IDX, micl_pkg::A_INFO_RD,
            micl_pkg::A_CFG_IDX, micl_pkg::A_CFG_RD, micl_pkg::A_CFG_CNT: known_addr = 1'b1;
            default: known_addr = 1'b0;
        endcase
    endfunction

    // The temperature difference flag is deliberately absent here.
    assign temp_fault = t1_open | t1_short | t2_open | t2_short;
    // Overflow beyond approved flow keeps measuring.
    assign flow_fault = air_in_flow | flow_reversed;

    always_comb begin
        status_next = '0;
        status_next[micl_pkg::B_LOWBAT] = low_battery;
        status_next[micl_pkg::B_EXTALM] = ext_alarm;
        status_next[micl_pkg::B_T1_HI] = t1_open;
        status_next[micl_pkg::B_T2_HI] = t2_open;
        status_next[micl_pkg::B_T1_LO] = t1_short;
        status_next[micl_pkg::B_T2_LO] = t2_short;
        status_next[micl_pkg::B_DT] = dt_invalid;
        status_next[micl_pkg::B_AIR] = air_in_flow;
        status_next[micl_pkg::B_REV] = flow_reversed;
        status_next[micl_pkg::B_OVER] = flow_over_1h;
        status_next[micl_pkg::B_LEAKA] = leak_a;
        status_next[micl_pkg::B_LEAKB] = leak_b;
        status_next[micl_pkg::B_ALMA] = alarm_a;
        status_next[micl_pkg::B_ALMB] = alarm_b;
    end

    // Bit 0 is never set in the live word; it is only logged after a supply loss.
    assign status_word = prev_reg;
    // Heat and cooling both depend on the temperature and flow sensors.
    assign heat_acc_en = ~(temp_fault | flow_fault);
    assign cool_acc_en = ~(temp_fault | flow_fault);
    assign dash_temp = temp_fault;
    assign dash_flow = flow_fault;
    assign dash_power = temp_fault | flow_fault;
    assign info_flash = flash_reg;
    assign radio_on = radio_reg;
    assign setup_open = setup_open_reg;

    assign wr_en = psel & penable & pwrite & clk_en;
    // Read data is captured in the setup cycle, so a read is recognised while penable is low.
    assign rd_en = psel & ~penable & ~pwrite & clk_en;
    assign unmapped = ~known_addr(paddr);
    assign pready = 1'b1;
    assign pslverr = psel & penable & unmapped;

    assign event_now = ((status_next ^ prev_reg) & mask_reg) != '0
        && mode_reg != micl_pkg::MICL_TRANSPORT && !top_separated;
    assign cfg_log = setup_exit && cfg_cnt_reg < (CIDX_W + 1)'(micl_pkg::CFG_MAX);

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            meas_reg <= '0;
        end else if (clk_en) begin
            meas_reg <= meas_raw;
            if (t1_short) meas_reg.t1 <= micl_pkg::T_MIN;
            else if (t1_open) meas_reg.t1 <= micl_pkg::T_MAX;
            if (t2_short) meas_reg.t2 <= micl_pkg::T_MIN;
            else if (t2_open) meas_reg.t2 <= micl_pkg::T_MAX;
            if (flow_fault) meas_reg.flow <= micl_pkg::FLOW_ERR;
            if (temp_fault | flow_fault) meas_reg.power <= micl_pkg::POWER_ERR;
        end
    end

    // Mode machine: transport is left once and only a reset brings it back.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            mode_reg <= micl_pkg::MICL_TRANSPORT;
        end else if (clk_en) begin
            case (mode_reg)
                micl_pkg::MICL_TRANSPORT: begin
                    if (integration) mode_reg <= micl_pkg::MICL_NORMAL;
                    else if (wr_en && paddr == micl_pkg::A_CTRL && pwdata[micl_pkg::C_FINISH])
                        mode_reg <= micl_pkg::MICL_NORMAL;
                    else if (test_menu_enter) mode_reg <= micl_pkg::MICL_TEST;
                end
                micl_pkg::MICL_NORMAL: begin
                    if (test_menu_enter) mode_reg <= micl_pkg::MICL_TEST;
                end
                micl_pkg::MICL_TEST: begin
                    if (wr_en && paddr == micl_pkg::A_CTRL && pwdata[micl_pkg::C_LEAVE])
                        mode_reg <= micl_pkg::MICL_NORMAL;
                end
                default: mode_reg <= micl_pkg::MICL_TRANSPORT;
            endcase
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            meas_seq <= 2'h0;
        end else if (clk_en) begin
            meas_seq <= (mode_reg == micl_pkg::MICL_TRANSPORT) ? 2'h0 : rate_code;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            radio_reg <= 1'b0;
        end else if (clk_en) begin
            if (test_menu_enter || mode_reg == micl_pkg::MICL_TEST) radio_reg <= 1'b0;
            else if (integration || forced_dialup) radio_reg <= 1'b1;
            else if (wr_en && paddr == micl_pkg::A_CTRL && pwdata[micl_pkg::C_RADIO])
                radio_reg <= 1'b1;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            setup_open_reg <= 1'b1;
        end else if (clk_en) begin
            if (wr_en && paddr == micl_pkg::A_CTRL && pwdata[micl_pkg::C_FINISH])
                setup_open_reg <= 1'b0;
            else if (top_separated) setup_open_reg <= 1'b1;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            mask_reg <= micl_pkg::MASK_RST;
        end else if (wr_en && paddr == micl_pkg::A_MASK) begin
            mask_reg <= pwdata[15:0];
        end
    end

    // Info log: the supply-loss bit is pushed in once after a restore.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prev_reg <= '0;
            evcnt_reg <= '0;
            wptr_reg <= '0;
            supply_pend_reg <= 1'b0;
        end else if (clk_en) begin
            prev_reg <= status_next;
            if (event_now || (supply_pend_reg && mode_reg != micl_pkg::MICL_TRANSPORT)) begin
                evcnt_reg <= evcnt_reg + 16'h0001;
                supply_pend_reg <= 1'b0;
                wptr_reg <= (wptr_reg == IDX_W'(micl_pkg::INFO_DEPTH - 1)) ? '0
                    : wptr_reg + IDX_W'(1);
            end
            // A restore that meets an entry being written stays queued for the next entry.
            if (supply_restored) supply_pend_reg <= 1'b1;
        end
    end

    always_ff @(posedge pclk) begin
        if (clk_en && (event_now || (supply_pend_reg && mode_reg != micl_pkg::MICL_TRANSPORT)))
        begin
            info_mem[wptr_reg] <= '{stamp: time_stamp,
                status: status_next | {15'h0000, supply_pend_reg},
                heat: heat_energy_register, cool: cooling_energy_register};
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cfg_cnt_reg <= '0;
        end else if (clk_en && cfg_log) begin
            cfg_cnt_reg <= cfg_cnt_reg + (CIDX_W + 1)'(1);
        end
    end

    always_ff @(posedge pclk) begin
        if (clk_en && cfg_log) begin
            cfg_mem[cfg_cnt_reg[CIDX_W-1:0]] <= '{stamp: time_stamp, cfg_no: cfg_number,
                heat: heat_energy_register, cool: cooling_energy_register,
                vol: volume_count, hours: hour_count, t_offset: temp_offset};
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            info_idx_reg <= '0;
            cfg_idx_reg <= '0;
        end else if (wr_en) begin
            if (paddr == micl_pkg::A_INFO_IDX) info_idx_reg <= pwdata[IDX_W-1:0];
            if (paddr == micl_pkg::A_CFG_IDX) cfg_idx_reg <= pwdata[CIDX_W-1:0];
        end
    end

    // Blinking the alert at a slow divided rate keeps the display readable.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            flash_cnt_reg <= '0;
            flash_reg <= 1'b0;
        end else if (clk_en) begin
            flash_cnt_reg <= flash_cnt_reg + 8'h01;
            if (flash_cnt_reg == 8'(FLASH_DIV - 1)) begin
                flash_cnt_reg <= '0;
                flash_reg <= (prev_reg != '0) ? ~flash_reg : 1'b0;
            end
            if (prev_reg == '0) flash_reg <= 1'b0;
        end
    end

    // Read data is registered; the reading index must be written beforehand.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata <= '0;
        end else if (rd_en) begin
            case (paddr)
                micl_pkg::A_STATUS: prdata <= {16'h0000, prev_reg};
                micl_pkg::A_MASK: prdata <= {16'h0000, mask_reg};
                micl_pkg::A_STATE: prdata <= {26'h0, meas_seq, setup_open_reg, radio_reg,
                    mode_reg};
                micl_pkg::A_EVCNT: prdata <= {16'h0000, evcnt_reg};
                micl_pkg::A_T1: prdata <= {16'h0000, meas_reg.t1};
                micl_pkg::A_T2: prdata <= {16'h0000, meas_reg.t2};
                micl_pkg::A_FLOW: prdata <= {16'h0000, meas_reg.flow};
                micl_pkg::A_POWER: prdata <= {16'h0000, meas_reg.power};
                micl_pkg::A_INFO_RD: prdata <= {info_mem[info_idx_reg].stamp[15:0],
                    info_mem[info_idx_reg].status};
                micl_pkg::A_CFG_RD: prdata <= {cfg_mem[cfg_idx_reg].stamp[15:0],
                    cfg_mem[cfg_idx_reg].cfg_no};
                micl_pkg::A_CFG_CNT: prdata <= {{(31 - CIDX_W){1'b0}}, cfg_cnt_reg};
                default: prdata <= '0;
            endcase
        end
    end

    transport_once_a: assert property (@(posedge pclk) disable iff (!presetn)
        mode_reg != micl_pkg::MICL_TRANSPORT |=> mode_reg != micl_pkg::MICL_TRANSPORT)
        else $error("transport state re-entered");
    no_log_transport_a: assert property (@(posedge pclk) disable iff (!presetn)
        mode_reg == micl_pkg::MICL_TRANSPORT |=> $stable(evcnt_reg))
        else $error("event counted in transport");
    leave_on_flow_a: assert property (@(posedge pclk) disable iff (!presetn)
        clk_en && integration && mode_reg == micl_pkg::MICL_TRANSPORT
        |=> mode_reg == micl_pkg::MICL_NORMAL) else $error("first flow kept transport");
    temp_subst_a: assert property (@(posedge pclk) disable iff (!presetn)
        clk_en && t1_open && !t1_short |=> meas_reg.t1 == micl_pkg::T_MAX)
        else $error("open sensor not reported at top");
    power_zero_a: assert property (@(posedge pclk) disable iff (!presetn)
        clk_en && temp_fault |=> meas_reg.power == micl_pkg::POWER_ERR)
        else $error("power not zeroed");
    flow_zero_a: assert property (@(posedge pclk) disable iff (!presetn)
        clk_en && flow_fault |-> (dash_flow && dash_power)
        ##1 (meas_reg.flow == micl_pkg::FLOW_ERR))
        else $error("flow not zeroed");
    radio_test_a: assert property (@(posedge pclk) disable iff (!presetn)
        mode_reg == micl_pkg::MICL_TEST && clk_en |=> !radio_on)
        else $error("radio on in test menu");
    cfg_limit_a: assert property (@(posedge pclk) disable iff (!presetn)
        cfg_cnt_reg <= (CIDX_W + 1)'(micl_pkg::CFG_MAX)) else $error("too many config logs");
    supply_bit_a: assert property (@(posedge pclk) disable iff (!presetn)
        !status_word[micl_pkg::B_SUPPLY]) else $error("supply bit in live word");
    event_count_a: assert property (@(posedge pclk) disable iff (!presetn)
        event_now && clk_en |=> evcnt_reg == $past(evcnt_reg) + 16'h0001)
        else $error("event not counted");
endmodule
`default_nettype wire

// File: tb/micl_front.sv
`default_nettype none
// Front-end stand-in: steady raw readings and free-running counters for the log stamps.
module micl_front (
    // Clock and reset.
    input wire logic pclk,
    input wire logic presetn,
    // Readings towards the logger.
    output micl_pkg::micl_meas_t meas,
    output logic [31:0] stamp,
    output logic [31:0] vol,
    output logic [31:0] hours
);
    timeunit 1ns;
    timeprecision 1ps;
    assign meas = {16'h1234, 16'h0fa0, 16'h0320, 16'h0055};
    assign vol = stamp + 32'h00000100;
    assign hours = {8'h00, stamp[31:8]};
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            stamp <= 32'h00000000;
        end else begin
            stamp <= stamp + 32'h00000001;
        end
    end
endmodule
`default_nettype wire

// File: tb/tb.sv
`default_nettype none
module tb;
    timeunit 1ns;
    timeprecision 1ps;
    logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, pready, pslverr, top_sep = 0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0, prdata, stamp, vol, hours, rdat;
    logic [13:0] flt = 14'h0;
    logic [4:0] ev = 5'h00;
    logic ce = 1'b1;
    logic heat_en, cool_en, d_temp, d_flow, d_pow, flash, radio, setup;
    logic [1:0] seq;
    logic [15:0] status;
    micl_pkg::micl_meas_t meas;
    int failures = 0, tests_run = 0, cyc = 0, seen;
    int bits[14] = '{3, 4, 5, 6, 7, 8, 9, 11, 12, 13, 14, 15, 1, 2};
    micl_front u_front (.pclk(pclk), .presetn(presetn), .meas(meas), .stamp(stamp),
        .vol(vol), .hours(hours));
    micl_logger #(.FLASH_DIV(2)) u_dut (.pclk(pclk), .presetn(presetn), .clk_en(ce),
        .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .t1_open(flt[0]), .t2_open(flt[1]), .t1_short(flt[2]), .t2_short(flt[3]),
        .dt_invalid(flt[4]), .air_in_flow(flt[5]), .flow_reversed(flt[6]),
        .flow_over_1h(flt[7]), .leak_a(flt[8]), .leak_b(flt[9]), .alarm_a(flt[10]),
        .alarm_b(flt[11]), .low_battery(flt[12]), .ext_alarm(flt[13]),
        .supply_restored(ev[4]), .meas_raw(meas), .time_stamp(stamp),
        .heat_energy_register(stamp), .cooling_energy_register(vol), .volume_count(vol),
        .hour_count(hours), .temp_offset(16'h0011), .cfg_number(16'h0042),
        .integration(ev[0]), .forced_dialup(ev[1]), .setup_exit(ev[2]),
        .test_menu_enter(ev[3]), .top_separated(top_sep), .rate_code(2'h2),
        .heat_acc_en(heat_en), .cool_acc_en(cool_en), .dash_temp(d_temp),
        .dash_flow(d_flow), .dash_power(d_pow), .info_flash(flash), .radio_on(radio),
        .setup_open(setup), .meas_seq(seq), .status_word(status));
    initial begin
        forever #4 pclk = ~pclk;
    end
    task automatic close_out();
        $display("checks %0d failures %0d", tests_run, failures);
        if (failures == 0 && tests_run > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask
    always @(posedge pclk) begin
        cyc++;
        if (cyc == 20000) begin
            failures++;
            close_out();
        end
    end
    task automatic chk(input string n, input logic [31:0] e, input logic [31:0] s);
        tests_run++;
        if (s !== e) begin
            $display("mismatch %s expected %h seen %h", n, e, s);
            failures++;
        end
    endtask
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        @(posedge pclk);
        while (pready !== 1'b1) @(posedge pclk);
        rdat = prdata;
        seen = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task automatic rd(input logic [11:0] a, input logic [31:0] m, input logic [31:0] e);
        apb(1'b0, a, 32'h0);
        chk($sformatf("reg %h", a), e, rdat & m);
    endtask
    task automatic pulse(input int i);
        @(posedge pclk);
        ev[i] <= 1'b1;
        @(posedge pclk);
        ev <= 5'h00;
    endtask
    task automatic setf(input logic [13:0] v);
        @(posedge pclk);
        flt <= v;
        repeat (4) @(posedge pclk);
    endtask
    task automatic do_reset();
        @(posedge pclk);
        presetn <= 1'b0;
        repeat (5) @(posedge pclk);
        presetn <= 1'b1;
    endtask
    initial begin
        do_reset();
        rd(micl_pkg::A_STATE, 32'h3f, 32'h08);
        rd(micl_pkg::A_MASK, 32'hffff, 32'hfbff);
        rd(12'h0fc, 32'hffffffff, 32'h0);
        chk("unmapped error", 32'h1, 32'(seen));
        for (int i = 0; i < 14; i++) begin
            setf(14'h1 << i);
            chk($sformatf("status %0d", i), 32'h1 << bits[i], 32'(status));
        end
        rd(micl_pkg::A_EVCNT, 32'hffffffff, 32'h0);
        setf(14'h004);
        rd(micl_pkg::A_T1, 32'hffff, 32'(micl_pkg::T_MIN));
        rd(micl_pkg::A_POWER, 32'hffff, 32'(micl_pkg::POWER_ERR));
        chk("dash t p en", 32'hc, 32'({d_temp, d_pow, heat_en, cool_en}));
        seen = 0;
        repeat (8) @(posedge pclk) seen = seen | (1 << int'(flash === 1'b1));
        chk("flash", 32'h3, 32'(seen));
        setf(14'h001);
        rd(micl_pkg::A_T1, 32'hffff, 32'(micl_pkg::T_MAX));
        setf(14'h010);
        chk("dt only", 32'h3, 32'({d_temp, d_pow, heat_en, cool_en}));
        rd(micl_pkg::A_T2, 32'hffff, 32'h0fa0);
        setf(14'h020);
        rd(micl_pkg::A_FLOW, 32'hffff, 32'(micl_pkg::FLOW_ERR));
        rd(micl_pkg::A_POWER, 32'hffff, 32'(micl_pkg::POWER_ERR));
        chk("air", 32'hc, 32'({d_flow, d_pow, heat_en, cool_en}));
        setf(14'h080);
        rd(micl_pkg::A_FLOW, 32'hffff, 32'h0320);
        chk("over", 32'h3, 32'({d_flow, d_pow, heat_en, cool_en}));
        setf(14'h0);
        pulse(1);
        rd(micl_pkg::A_STATE, 32'h37, 32'h04);
        pulse(0);
        rd(micl_pkg::A_STATE, 32'h37, 32'h25);
        setf(14'h008);
        rd(micl_pkg::A_EVCNT, 32'hffffffff, 32'h1);
        apb(1'b1, micl_pkg::A_INFO_IDX, 32'h0);
        rd(micl_pkg::A_INFO_RD, 32'hffff, 32'h0040);
        setf(14'h0);
        apb(1'b1, micl_pkg::A_MASK, 32'h0000ffef);
        setf(14'h002);
        setf(14'h0);
        rd(micl_pkg::A_EVCNT, 32'hffffffff, 32'h2);
        ce <= 1'b0;
        apb(1'b1, micl_pkg::A_MASK, 32'h0000ffff);
        ce <= 1'b1;
        rd(micl_pkg::A_MASK, 32'hffff, 32'hffef);
        top_sep <= 1'b1;
        setf(14'h004);
        rd(micl_pkg::A_EVCNT, 32'hffffffff, 32'h2);
        top_sep <= 1'b0;
        pulse(4);
        rd(micl_pkg::A_EVCNT, 32'hffffffff, 32'h3);
        apb(1'b1, micl_pkg::A_INFO_IDX, 32'h2);
        rd(micl_pkg::A_INFO_RD, 32'hffff, 32'h0021);
        chk("live supply", 32'h20, 32'(status));
        pulse(3);
        pulse(0);
        pulse(1);
        apb(1'b1, micl_pkg::A_CTRL, 32'h2);
        rd(micl_pkg::A_STATE, 32'h07, 32'h02);
        apb(1'b1, micl_pkg::A_CTRL, 32'h8);
        rd(micl_pkg::A_STATE, 32'h07, 32'h01);
        apb(1'b1, micl_pkg::A_CTRL, 32'h2);
        rd(micl_pkg::A_STATE, 32'h07, 32'h05);
        pulse(2);
        rd(micl_pkg::A_CFG_CNT, 32'hffffffff, 32'h1);
        apb(1'b1, micl_pkg::A_CFG_IDX, 32'h0);
        rd(micl_pkg::A_CFG_RD, 32'hffff, 32'h0042);
        repeat (26) pulse(2);
        rd(micl_pkg::A_CFG_CNT, 32'hffffffff, 32'd25);
        do_reset();
        rd(micl_pkg::A_CFG_CNT, 32'hffffffff, 32'h0);
        apb(1'b1, micl_pkg::A_CTRL, 32'h1);
        rd(micl_pkg::A_STATE, 32'h3f, 32'h21);
        pulse(0);
        rd(micl_pkg::A_STATE, 32'h3f, 32'h25);
        close_out();
    end
endmodule
`default_nettype wire
